// *** sfc_consts.vh ***
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH
`define SFC_TRAIN_WORDS 4'hA
`define SFC_THR_MIN 9'h001
`define SFC_THR_MAX 9'h1FC
`define SFC_CODE_FRAME 2'h3
`define SFC_CODE_SAT 2'h2
`define SFC_POL_OOF 2'h0
`define SFC_POL_SAT 2'h1
`define SFC_DIV4_HALF 2'h1
`define SFC_DIV8_HALF 2'h3
`endif

// *** sfc_cal_regs.v ***
`timescale 1ns/100ps
`include "sfc_consts.vh"
module sfc_cal_regs (
  input wire status_write_clock,
  input wire reset_n,
  input wire sink_enable,
  input wire [7:0] calendar_repeat_setting,
  input wire [8:0] calendar_length_setting,
  output reg [7:0] cal_repeat_r,
  output reg [8:0] cal_len_r
);
  // enable arrives from the mclk side, two flops before use
  reg en_s1_r;
  reg en_s2_r;
  // settings load only while the sink is disabled
  always @(posedge status_write_clock or negedge reset_n) begin
    if (!reset_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      cal_repeat_r <= 8'h00;
      cal_len_r <= 9'h000;
    end else begin
      en_s1_r <= sink_enable;
      en_s2_r <= en_s1_r;
      if (!en_s2_r) begin
        cal_repeat_r <= calendar_repeat_setting;
        cal_len_r <= calendar_length_setting;
      end
    end
  end
endmodule // sfc_cal_regs

// *** sfc_sink_flow.v ***
`timescale 1ns/100ps
`include "sfc_consts.vh"
module sfc_sink_flow (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire status_write_clock,
  input wire sink_enable,
  input wire [3:0] dip4_error_limit,
  input wire [3:0] training_pattern_count,
  input wire [7:0] calendar_repeat_setting,
  input wire [8:0] calendar_length_setting,
  input wire [8:0] af_assert_threshold,
  input wire [8:0] af_release_threshold,
  input wire [1:0] almost_full_policy,
  input wire status_clock_ratio_sel,
  input wire status_edge_sel,
  input wire word_valid,
  input wire word_is_ctl,
  input wire word_is_train,
  input wire dip4_check,
  input wire dip4_error,
  input wire [8:0] free_count,
  input wire [1:0] user_status,
  output reg out_of_frame_flag,
  output reg accept_data,
  output reg almost_full_n_flag,
  output reg rsclk,
  output reg [1:0] rstat,
  output reg frame_slot,
  output reg [8:0] cal_index,
  output reg [7:0] cal_repeat_eff,
  output reg [9:0] cal_len_eff
);
  function [3:0] at_least_one;
    input [3:0] v;
    at_least_one = (v == 4'h0) ? 4'h1 : v;
  endfunction

  wire [7:0] cal_repeat_r;
  wire [8:0] cal_len_r;
  sfc_cal_regs u_cal (
    .status_write_clock(status_write_clock),
    .reset_n(reset_n),
    .sink_enable(sink_enable),
    .calendar_repeat_setting(calendar_repeat_setting),
    .calendar_length_setting(calendar_length_setting),
    .cal_repeat_r(cal_repeat_r),
    .cal_len_r(cal_len_r)
  );

  // sync enable; settings are quasi-static while enabled
  reg en_s1_r, en_s2_r;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else if (clk_en) begin
      en_s1_r <= sink_enable;
      en_s2_r <= en_s1_r;
    end
  end

  // calendar words from the write clock domain, held while enabled and following the settings while disabled
  reg [7:0] rep_s1_r;
  reg [7:0] rep_s2_r;
  reg [8:0] len_s1_r;
  reg [8:0] len_s2_r;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rep_s1_r <= 8'h00;
      rep_s2_r <= 8'h00;
      len_s1_r <= 9'h000;
      len_s2_r <= 9'h000;
    end else if (clk_en) begin
      rep_s1_r <= cal_repeat_r;
      rep_s2_r <= rep_s1_r;
      len_s1_r <= cal_len_r;
      len_s2_r <= len_s1_r;
    end
  end

  wire [3:0] err_lim = at_least_one(dip4_error_limit);
  wire [3:0] pat_lim = at_least_one(training_pattern_count);

  wire [8:0] thr_a = (af_assert_threshold < `SFC_THR_MIN) ? `SFC_THR_MIN :
    (af_assert_threshold > `SFC_THR_MAX) ? `SFC_THR_MAX : af_assert_threshold;
  wire [8:0] thr_r = (af_release_threshold < thr_a) ? thr_a :
    (af_release_threshold > `SFC_THR_MAX) ? `SFC_THR_MAX : af_release_threshold;

  // almost full with hysteresis
  reg af_nxt;
  always @* begin
    af_nxt = almost_full_n_flag;
    if (free_count <= thr_a)
      af_nxt = 1'b0;
    else if (free_count >= thr_r)
      af_nxt = 1'b1;
  end // between thresholds: hold

  wire af_oof = !almost_full_n_flag && (almost_full_policy == `SFC_POL_OOF);

  // framing: dip4 error run and training pattern detection
  reg [3:0] err_run_r, pat_run_r, tw_cnt_r;
  reg tw_phase_r; // 0: control words, 1: data words
  reg oof_r;
  wire ctl_tw = word_valid && word_is_train && word_is_ctl;
  wire dat_tw = word_valid && word_is_train && !word_is_ctl;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_run_r <= 4'h0;
      pat_run_r <= 4'h0;
      tw_cnt_r <= 4'h0;
      tw_phase_r <= 1'b0;
      oof_r <= 1'b1;
    end else if (clk_en) begin
      if (!en_s2_r) begin
        oof_r <= 1'b1;
        err_run_r <= 4'h0;
        pat_run_r <= 4'h0;
        tw_cnt_r <= 4'h0;
        tw_phase_r <= 1'b0;
      end else if (!oof_r) begin
        if (dip4_check) begin
          if (!dip4_error)
            err_run_r <= 4'h0;
          else if (err_run_r + 4'h1 >= err_lim) begin
            oof_r <= 1'b1;
            err_run_r <= 4'h0;
            pat_run_r <= 4'h0;
          end else
            err_run_r <= err_run_r + 4'h1;
        end
      end else if (word_valid) begin
        // ten control then ten data training words form one pattern
        if (!tw_phase_r && ctl_tw) begin
          tw_cnt_r <= (tw_cnt_r == `SFC_TRAIN_WORDS - 4'h1) ? 4'h0 : tw_cnt_r + 4'h1;
          tw_phase_r <= (tw_cnt_r == `SFC_TRAIN_WORDS - 4'h1);
        end else if (tw_phase_r && dat_tw) begin
          if (tw_cnt_r == `SFC_TRAIN_WORDS - 4'h1) begin
            tw_cnt_r <= 4'h0;
            tw_phase_r <= 1'b0;
            if (pat_run_r + 4'h1 >= pat_lim) begin
              oof_r <= 1'b0;
              pat_run_r <= 4'h0;
            end else
              pat_run_r <= pat_run_r + 4'h1;
          end else
            tw_cnt_r <= tw_cnt_r + 4'h1;
        end else begin
          // broken pattern: restart back to back count
          tw_cnt_r <= ctl_tw ? 4'h1 : 4'h0;
          tw_phase_r <= 1'b0;
          pat_run_r <= 4'h0;
        end
      end
    end
  end

  // status clock divider and calendar sequencing
  reg [2:0] div_r;
  reg [8:0] idx_r;
  reg [7:0] rep_r;
  reg dip_slot_r;
  wire [1:0] half = status_clock_ratio_sel ? `SFC_DIV8_HALF : `SFC_DIV4_HALF;
  wire tick = (div_r[1:0] == half);
  wire clk_nxt = rsclk ^ tick;
  wire upd = tick && (status_edge_sel ? !clk_nxt : clk_nxt);

  reg [1:0] code_nxt;
  always @* begin
    if (!almost_full_n_flag && almost_full_policy == `SFC_POL_OOF)
      code_nxt = `SFC_CODE_FRAME;
    else if (dip_slot_r || oof_r)
      code_nxt = `SFC_CODE_FRAME;
    else if (!almost_full_n_flag && almost_full_policy == `SFC_POL_SAT)
      code_nxt = `SFC_CODE_SAT;
    else
      code_nxt = user_status;
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 3'h0;
      rsclk <= 1'b0;
      rstat <= `SFC_CODE_FRAME;
      idx_r <= 9'h000;
      rep_r <= 8'h00;
      dip_slot_r <= 1'b1;
      frame_slot <= 1'b0;
      almost_full_n_flag <= 1'b1;
      out_of_frame_flag <= 1'b1;
      accept_data <= 1'b0;
      cal_index <= 9'h000;
      cal_repeat_eff <= 8'h00;
      cal_len_eff <= 10'h000;
    end else if (clk_en) begin
      almost_full_n_flag <= af_nxt;
      out_of_frame_flag <= oof_r || af_oof;
      accept_data <= !(oof_r || af_oof);
      cal_repeat_eff <= rep_s2_r;
      cal_len_eff <= {1'b0, len_s2_r} + 10'h001;
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      rsclk <= clk_nxt;
      if (upd) begin
        rstat <= code_nxt;
        frame_slot <= dip_slot_r;
        cal_index <= idx_r;
        if (dip_slot_r) begin
          dip_slot_r <= 1'b0;
          idx_r <= 9'h000;
          rep_r <= 8'h00;
        end else if (idx_r == len_s2_r) begin
          idx_r <= 9'h000;
          if (rep_r == rep_s2_r)
            dip_slot_r <= 1'b1;
          else
            rep_r <= rep_r + 8'h01;
        end else
          idx_r <= idx_r + 9'h001;
      end
    end
  end
endmodule // sfc_sink_flow

// *** sfc_sink_flow_sva.sv ***
`timescale 1ns/100ps
module sfc_sink_flow_sva (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire [8:0] af_assert_threshold,
  input wire [8:0] af_release_threshold,
  input wire [1:0] almost_full_policy,
  input wire status_clock_ratio_sel,
  input wire status_edge_sel,
  input wire [8:0] free_count,
  input wire out_of_frame_flag,
  input wire accept_data,
  input wire almost_full_n_flag,
  input wire rsclk,
  input wire [1:0] rstat,
  input wire frame_slot
);
  wire [8:0] ath = af_assert_threshold == 9'h000 ? 9'h001 :
    (af_assert_threshold > 9'h1FC ? 9'h1FC : af_assert_threshold);
  wire [8:0] rlm = af_release_threshold > 9'h1FC ? 9'h1FC : af_release_threshold;
  wire [8:0] rth = rlm < ath ? ath : rlm;
  wire af0 = !almost_full_n_flag && almost_full_policy == 2'h0;
  wire af1 = !almost_full_n_flag && almost_full_policy == 2'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n || !clk_en);
  accept_inv_a: assert property (accept_data != out_of_frame_flag) else $error("accept not inverse");
  af_set_a: assert property ($fell(almost_full_n_flag) |-> $past(free_count) <= ath)
    else $error("af set early");
  af_clear_a: assert property ($rose(almost_full_n_flag) |-> $past(free_count) >= rth)
    else $error("af cleared early");
  pol_oof_a: assert property (af0[*3] |-> out_of_frame_flag) else $error("policy 0 in frame");
  pol_frame_a: assert property (af0[*8] ##1 af0[*4] |-> rstat == 2'h3) else $error("no framing code");
  pol_sat_a: assert property (af1[*8] ##1 af1[*4] |-> frame_slot || rstat == 2'h2)
    else $error("no satisfied code");
  div_four_a: assert property ($rose(rsclk) && !status_clock_ratio_sel |=> rsclk ##1 (!rsclk)[*2] ##1 rsclk)
    else $error("status clock not quarter");
  div_eight_a: assert property ($rose(rsclk) && status_clock_ratio_sel |=> rsclk[*3] ##1 (!rsclk)[*4] ##1 rsclk)
    else $error("status clock not eighth");
  rstat_edge_a: assert property ($changed(rstat) |-> (status_edge_sel ? $fell(rsclk) : $rose(rsclk)))
    else $error("status changed on wrong edge");
endmodule // sfc_sink_flow_sva
bind sfc_sink_flow sfc_sink_flow_sva u_sva (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
  .af_assert_threshold(af_assert_threshold), .af_release_threshold(af_release_threshold),
  .almost_full_policy(almost_full_policy), .status_clock_ratio_sel(status_clock_ratio_sel),
  .status_edge_sel(status_edge_sel), .free_count(free_count), .out_of_frame_flag(out_of_frame_flag),
  .accept_data(accept_data), .almost_full_n_flag(almost_full_n_flag), .rsclk(rsclk), .rstat(rstat),
  .frame_slot(frame_slot));

// *** sfc_tx_model.sv ***
`timescale 1ns/100ps
module sfc_tx_model (
  input wire mclk,
  output reg word_valid,
  output reg word_is_ctl,
  output reg word_is_train,
  output reg dip4_check,
  output reg dip4_error
);
  initial {word_valid, word_is_ctl, word_is_train, dip4_check, dip4_error} = 5'h00;
  task send(input v, input c, input t, input k, input e);
    @(posedge mclk) #1;
    {word_valid, word_is_ctl, word_is_train, dip4_check, dip4_error} = {v, c, t, k, e};
  endtask
  // nd below ten breaks the pattern with plain data words
  task pattern(input integer nd);
    integer i;
    for (i = 0; i < 20; i = i + 1)
      send(1'b1, i < 10, i < 10 + nd, 1'b0, 1'b0);
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task dip4(input e);
    send(1'b1, 1'b0, 1'b0, 1'b1, e);
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask
endmodule // sfc_tx_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  reg mclk, reset_n, swc, sink_enable, clk_en;
  reg [1:0] pol, user_status;
  reg [8:0] free_count, len, ath, rth;
  reg [7:0] rep;
  reg [3:0] dlim, pcnt;
  reg [2:0] snap;
  wire oof, acc, afn, rsclk, fslot, wv, wc, wt, dk, de;
  wire [1:0] rstat;
  wire [7:0] rep_eff;
  wire [8:0] ci;
  wire [9:0] len_eff;
  integer error_cnt = 0, n_tests = 0, m, c;
  time t0;
  sfc_tx_model u_tx (.mclk(mclk), .word_valid(wv), .word_is_ctl(wc), .word_is_train(wt), .dip4_check(dk),
    .dip4_error(de));
  sfc_sink_flow u_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .status_write_clock(swc),
    .sink_enable(sink_enable), .dip4_error_limit(dlim), .training_pattern_count(pcnt),
    .calendar_repeat_setting(rep), .calendar_length_setting(len), .af_assert_threshold(ath),
    .af_release_threshold(rth), .almost_full_policy(pol), .status_clock_ratio_sel(pol[0]),
    .status_edge_sel(pol[1]), .word_valid(wv), .word_is_ctl(wc), .word_is_train(wt), .dip4_check(dk),
    .dip4_error(de), .free_count(free_count), .user_status(user_status), .out_of_frame_flag(oof),
    .accept_data(acc), .almost_full_n_flag(afn), .rsclk(rsclk), .rstat(rstat), .frame_slot(fslot),
    .cal_index(ci), .cal_repeat_eff(rep_eff), .cal_len_eff(len_eff));
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    swc = 0;
    forever #32 swc = ~swc;
  end
  task chk(input [9:0] s, input [9:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task fs_rise;
    c = 0;
    while (fslot !== 1'b0 && c < 200) begin cyc(1); c = c + 1; end
    while (fslot !== 1'b1 && c < 200) begin cyc(1); c = c + 1; end
    if (c >= 200) begin error_cnt = error_cnt + 1; tally_and_finish; end
  endtask
  initial begin
    reset_n = 0; sink_enable = 0; user_status = 2'h1; free_count = 9'h1FF; len = 9'h002;
    clk_en = 1; pcnt = 4'h2; ath = 9'h000; rth = 9'h1FF;
    for (m = 0; m < 4; m = m + 1) begin
      reset_n = 0; sink_enable = 0; pol = m; rep = 8'h01; dlim = m;
      cyc(12); reset_n = 1; cyc(20);
      chk(len_eff, 10'h003);
      sink_enable = 1; cyc(40);
      rep = 8'h05; cyc(20);
      chk({2'h0, rep_eff}, 10'h001);
      u_tx.pattern(10); cyc(3);
      chk(oof, 1'b1);
      u_tx.pattern(0); u_tx.pattern(10); cyc(3);
      chk(oof, 1'b1);
      u_tx.pattern(10); cyc(3);
      chk(oof, 1'b0);
      fs_rise; t0 = $time; fs_rise;
      chk(10'(($time - t0) / 8), pol[0] ? 10'h038 : 10'h01C);
      clk_en = 0; snap = {rsclk, rstat}; cyc(10);
      chk({7'h00, rsclk, rstat}, {7'h00, snap});
      clk_en = 1;
      free_count = 9'h002; cyc(4);
      chk(afn, 1'b1);
      free_count = 9'h001; cyc(20);
      chk(afn, 1'b0);
      chk(oof, pol == 2'h0);
      fs_rise; cyc(pol[0] ? 12 : 6);
      chk(rstat, pol == 2'h0 ? 2'h3 : (pol == 2'h1 ? 2'h2 : 2'h1));
      free_count = 9'h1FB; cyc(4);
      chk(afn, 1'b0);
      free_count = 9'h1FC; cyc(4);
      chk(afn, 1'b1);
      fs_rise; cyc(pol[0] ? 12 : 6);
      chk(rstat, 2'h1);
      cyc(pol[0] ? 8 : 4);
      chk({1'b0, ci}, 10'h001);
      for (c = 1; c < m; c = c + 1) u_tx.dip4(1'b1);
      u_tx.dip4(1'b0);
      for (c = 1; c < m; c = c + 1) u_tx.dip4(1'b1);
      cyc(4);
      chk(acc, 1'b1);
      u_tx.dip4(1'b1); cyc(4);
      chk(acc, 1'b0);
      $display("test policy %0d done", m);
    end
    tally_and_finish;
  end
endmodule // tb_top
